// file: fap_pkg.sv
// package for the fault latch and phase register group: indices, field layouts, reset values and timing counts
// assumes a 250 MHz system clock and an AXI4-Lite register port with 32-bit data
// Operation
// R01 - channel 0 latch: OCP b0, flycap b2, DC b3
// R02 - channel 1 latch uses channel 0 layout
// R03 - device latch: temperature, undervoltage, overvoltage, lowtemp bits
// R04 - device latch: audio input b6, clock lock b5
// R05 - release delay after silence pin goes high
// R06 - phase delay in 22.5 degree steps
// R07 - phase code sixteen equals zero phase
// R08 - phase offset counted from shared sync edge
// R09 - writing one to clear resets latches
// R10 - live device vector readable, same layout
// R11 - latch bits hold until clear or reset
package fap_pkg;

  // ****************************************
  // register indices (byte address is four times the index)
  // ****************************************
  localparam logic [9:0] IDX_FAULT_TRIGGER_CLEAR = 10'h109;
  localparam logic [9:0] IDX_DEVICE_FAULT_LIVE = 10'h11A;
  localparam logic [9:0] IDX_CHANNEL0_FAULT_LATCH = 10'h11C;
  localparam logic [9:0] IDX_CHANNEL1_FAULT_LATCH = 10'h11D;
  localparam logic [9:0] IDX_DEVICE_FAULT_LATCH = 10'h11E;
  localparam logic [9:0] IDX_AUDIO_RELEASE_DELAY = 10'h142;
  localparam logic [9:0] IDX_OUTPUT_PHASE_OFFSET = 10'h15F;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h170;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h171;

  // ****************************************
  // field layouts and reset values
  // ****************************************
  localparam logic [4:0] CH_FAULT_VALID = 5'h0D;
  localparam logic [7:0] DEV_FAULT_VALID = 8'hF7;
  localparam logic [3:0] RELEASE_DELAY_RESET = 4'h3;
  localparam logic [6:0] PHASE_OFFSET_RESET = 7'h00;
  localparam logic [3:0] RELEASE_CODE_LONG = 4'h3;
  localparam logic [3:0] RELEASE_CODE_SHORT = 4'hD;
  localparam int IRQ_W = 4;
  localparam int IRQ_BIT_CH0 = 0;
  localparam int IRQ_BIT_CH1 = 1;
  localparam int IRQ_BIT_DEV = 2;
  localparam int IRQ_BIT_RELEASE = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 250_000_000;
  localparam int RELEASE_LONG_MS = 300;
  localparam int RELEASE_SHORT_MS = 30;
  localparam int RELEASE_LONG_CYCLES = (CLK_HZ / 1000) * RELEASE_LONG_MS;
  localparam int RELEASE_SHORT_CYCLES = (CLK_HZ / 1000) * RELEASE_SHORT_MS;
  localparam int PHASE_STEPS_PER_TURN = 16;
  localparam int PWM_PERIOD_CYCLES = 1024;

  typedef struct packed {
    logic [4:0] ch0;
    logic [4:0] ch1;
    logic [7:0] dev;
  } fap_fault_type;

endpackage

// file: fap_regs.sv
// fault latch, audio release delay and pwm phase register group with an AXI4-Lite slave port
// assumes fault conditions come from logic on REF_CLK; silence pin and sync pin are asynchronous
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module fap_regs #(
  parameter int RELEASE_LONG_CYCLES = fap_pkg::RELEASE_LONG_CYCLES,
  parameter int RELEASE_SHORT_CYCLES = fap_pkg::RELEASE_SHORT_CYCLES,
  parameter int PWM_PERIOD_CYCLES = fap_pkg::PWM_PERIOD_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire fap_pkg::fap_fault_type FAULT_LIVE,
  input wire logic SILENCE_PIN_N,
  input wire logic PWM_SYNC_IN,
  output logic AUDIO_RELEASE,
  output logic PWM_FRAME_START,
  output logic IRQ
);

  localparam int CNT_W = $clog2(RELEASE_LONG_CYCLES + 1);
  localparam int PH_W = $clog2(PWM_PERIOD_CYCLES);
  localparam int PHASE_STEP = PWM_PERIOD_CYCLES / fap_pkg::PHASE_STEPS_PER_TURN;

  // ****************************************
  // elaboration checks
  // ****************************************
  if (RELEASE_SHORT_CYCLES < 1 || RELEASE_LONG_CYCLES < RELEASE_SHORT_CYCLES) begin : g_bad_release
    $error("release counts must be positive and long not shorter than short");
  end
  if (PWM_PERIOD_CYCLES < 2 * fap_pkg::PHASE_STEPS_PER_TURN
      || (PWM_PERIOD_CYCLES % fap_pkg::PHASE_STEPS_PER_TURN) != 0) begin : g_bad_period
    $error("pwm period must be a multiple of sixteen and at least thirty-two");
  end

  function automatic logic [31:0] read_word(input logic [9:0] idx, input fap_pkg::fap_fault_type lat,
                                            input fap_pkg::fap_fault_type live, input logic [3:0] dly,
                                            input logic [6:0] ph, input logic [fap_pkg::IRQ_W-1:0] st,
                                            input logic [fap_pkg::IRQ_W-1:0] msk);
    logic [31:0] w;
    w = 32'h00000000;
    case (idx)
      fap_pkg::IDX_DEVICE_FAULT_LIVE: w[7:0] = live.dev & fap_pkg::DEV_FAULT_VALID; // R10
      fap_pkg::IDX_CHANNEL0_FAULT_LATCH: w[4:0] = lat.ch0;
      fap_pkg::IDX_CHANNEL1_FAULT_LATCH: w[4:0] = lat.ch1;
      fap_pkg::IDX_DEVICE_FAULT_LATCH: w[7:0] = lat.dev;
      fap_pkg::IDX_AUDIO_RELEASE_DELAY: w[3:0] = dly;
      fap_pkg::IDX_OUTPUT_PHASE_OFFSET: w[6:0] = ph;
      fap_pkg::IDX_IRQ_STATUS: w[fap_pkg::IRQ_W-1:0] = st;
      fap_pkg::IDX_IRQ_MASK: w[fap_pkg::IRQ_W-1:0] = msk;
      default: w = 32'h00000000;
    endcase
    return w;
  endfunction

  function automatic logic is_mapped(input logic [9:0] idx);
    logic m;
    m = 1'b0;
    case (idx)
      fap_pkg::IDX_FAULT_TRIGGER_CLEAR, fap_pkg::IDX_DEVICE_FAULT_LIVE,
      fap_pkg::IDX_CHANNEL0_FAULT_LATCH, fap_pkg::IDX_CHANNEL1_FAULT_LATCH,
      fap_pkg::IDX_DEVICE_FAULT_LATCH, fap_pkg::IDX_AUDIO_RELEASE_DELAY,
      fap_pkg::IDX_OUTPUT_PHASE_OFFSET, fap_pkg::IDX_IRQ_STATUS, fap_pkg::IDX_IRQ_MASK: m = 1'b1;
      default: m = 1'b0;
    endcase
    return m;
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic silence_meta_reg;
  logic silence_sync_reg;
  logic sync_meta_reg;
  logic sync_sync_reg;
  logic sync_prev_reg;

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      silence_meta_reg <= 1'b0;
      silence_sync_reg <= 1'b0;
      sync_meta_reg <= 1'b0;
      sync_sync_reg <= 1'b0;
      sync_prev_reg <= 1'b0;
    end else begin
      silence_meta_reg <= SILENCE_PIN_N;
      silence_sync_reg <= silence_meta_reg;
      sync_meta_reg <= PWM_SYNC_IN;
      sync_sync_reg <= sync_meta_reg;
      sync_prev_reg <= sync_sync_reg;
    end
  end

  // ****************************************
  // write channel
  // ****************************************
  logic aw_ready_reg;
  logic w_ready_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic [9:0] aw_idx_reg;
  logic [31:0] w_data_reg;
  logic w_lane0_reg;
  logic b_valid_reg;
  logic [1:0] b_resp_reg;
  logic aw_take;
  logic w_take;
  logic wr_do;
  logic wr_clear;

  assign aw_take = S_AXI_AWVALID && aw_ready_reg;
  assign w_take = S_AXI_WVALID && w_ready_reg;
  assign wr_do = aw_have_reg && w_have_reg && !b_valid_reg;
  // only byte lane 0 carries field bits; the other lanes are accepted and ignored
  assign wr_clear = wr_do && w_lane0_reg && aw_idx_reg == fap_pkg::IDX_FAULT_TRIGGER_CLEAR && w_data_reg[0]; // R09

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      aw_ready_reg <= 1'b1;
      aw_have_reg <= 1'b0;
      aw_idx_reg <= 10'h000;
    end else if (aw_take) begin
      aw_ready_reg <= 1'b0;
      aw_have_reg <= 1'b1;
      aw_idx_reg <= S_AXI_AWADDR[11:2];
    end else if (b_valid_reg && S_AXI_BREADY) begin
      aw_ready_reg <= 1'b1;
    end else if (wr_do) begin
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      w_ready_reg <= 1'b1;
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_lane0_reg <= 1'b0;
    end else if (w_take) begin
      w_ready_reg <= 1'b0;
      w_have_reg <= 1'b1;
      w_data_reg <= S_AXI_WDATA;
      w_lane0_reg <= S_AXI_WSTRB[0];
    end else if (b_valid_reg && S_AXI_BREADY) begin
      w_ready_reg <= 1'b1;
    end else if (wr_do) begin
      w_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      b_valid_reg <= 1'b0;
      b_resp_reg <= fap_pkg::RESP_OKAY;
    end else if (wr_do) begin
      b_valid_reg <= 1'b1;
      b_resp_reg <= is_mapped(aw_idx_reg) ? fap_pkg::RESP_OKAY : fap_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      b_valid_reg <= 1'b0;
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  logic [3:0] release_delay_reg;
  logic [6:0] phase_offset_reg;
  logic [fap_pkg::IRQ_W-1:0] irq_mask_reg;

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      release_delay_reg <= fap_pkg::RELEASE_DELAY_RESET;
      phase_offset_reg <= fap_pkg::PHASE_OFFSET_RESET;
      irq_mask_reg <= fap_pkg::IRQ_MASK_RESET;
    end else if (wr_do && w_lane0_reg) begin
      if (aw_idx_reg == fap_pkg::IDX_AUDIO_RELEASE_DELAY) begin
        release_delay_reg <= w_data_reg[3:0];
      end
      if (aw_idx_reg == fap_pkg::IDX_OUTPUT_PHASE_OFFSET) begin
        phase_offset_reg <= w_data_reg[6:0];
      end
      if (aw_idx_reg == fap_pkg::IDX_IRQ_MASK) begin
        irq_mask_reg <= w_data_reg[fap_pkg::IRQ_W-1:0];
      end
    end
  end

  // ****************************************
  // fault latches
  // ****************************************
  fap_pkg::fap_fault_type latch_reg;
  fap_pkg::fap_fault_type latch_next;
  fap_pkg::fap_fault_type live_masked;

  always_comb begin
    live_masked.ch0 = FAULT_LIVE.ch0 & fap_pkg::CH_FAULT_VALID; // R01
    live_masked.ch1 = FAULT_LIVE.ch1 & fap_pkg::CH_FAULT_VALID; // R02
    live_masked.dev = FAULT_LIVE.dev & fap_pkg::DEV_FAULT_VALID; // R03 R04
    // a fault present in the clearing cycle stays latched
    latch_next = (wr_clear ? '0 : latch_reg) | live_masked; // R09 R11
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      latch_reg <= '0;
    end else begin
      latch_reg <= latch_next; // R11
    end
  end

  // ****************************************
  // audio release delay
  // ****************************************
  logic [CNT_W-1:0] release_cnt_reg;
  logic release_reg;
  logic [CNT_W-1:0] release_target;

  // codes other than the long one take the short delay
  assign release_target = (release_delay_reg == fap_pkg::RELEASE_CODE_LONG)
                          ? CNT_W'(RELEASE_LONG_CYCLES) : CNT_W'(RELEASE_SHORT_CYCLES); // R05

  always_ff @(posedge REF_CLK) begin
    if (SRST || !silence_sync_reg) begin
      release_cnt_reg <= '0;
      release_reg <= 1'b0;
    end else if (!release_reg) begin
      release_cnt_reg <= release_cnt_reg + CNT_W'(1);
      release_reg <= (release_cnt_reg + CNT_W'(1)) >= release_target; // R05
    end
  end

  // ****************************************
  // pwm phase offset
  // ****************************************
  logic [PH_W-1:0] phase_cnt_reg;
  logic frame_start_reg;
  logic sync_edge;
  logic [PH_W-1:0] phase_point;

  assign sync_edge = sync_sync_reg && !sync_prev_reg;
  // low four bits only: a full turn of sixteen steps wraps to zero
  assign phase_point = PH_W'(phase_offset_reg[3:0]) * PH_W'(PHASE_STEP); // R06 R07

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      phase_cnt_reg <= '0;
    end else if (sync_edge) begin
      phase_cnt_reg <= PH_W'(1); // R08
    end else if (phase_cnt_reg == PH_W'(PWM_PERIOD_CYCLES - 1)) begin
      phase_cnt_reg <= '0;
    end else begin
      phase_cnt_reg <= phase_cnt_reg + PH_W'(1);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      frame_start_reg <= 1'b0;
    end else begin
      frame_start_reg <= sync_edge ? (phase_point == '0) : (phase_cnt_reg == phase_point); // R06 R08
    end
  end

  // ****************************************
  // read channel and interrupts
  // ****************************************
  logic ar_ready_reg;
  logic r_valid_reg;
  logic [31:0] r_data_reg;
  logic [1:0] r_resp_reg;
  logic ar_take;
  logic rd_status;
  logic release_prev_reg;
  logic [fap_pkg::IRQ_W-1:0] irq_status_reg;
  logic [fap_pkg::IRQ_W-1:0] irq_event;
  logic irq_reg;

  assign ar_take = S_AXI_ARVALID && ar_ready_reg;
  assign rd_status = ar_take && S_AXI_ARADDR[11:2] == fap_pkg::IDX_IRQ_STATUS;

  always_comb begin
    irq_event = '0;
    irq_event[fap_pkg::IRQ_BIT_CH0] = |(latch_next.ch0 & ~latch_reg.ch0);
    irq_event[fap_pkg::IRQ_BIT_CH1] = |(latch_next.ch1 & ~latch_reg.ch1);
    irq_event[fap_pkg::IRQ_BIT_DEV] = |(latch_next.dev & ~latch_reg.dev);
    irq_event[fap_pkg::IRQ_BIT_RELEASE] = release_reg && !release_prev_reg;
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ar_ready_reg <= 1'b1;
      r_valid_reg <= 1'b0;
      r_data_reg <= 32'h00000000;
      r_resp_reg <= fap_pkg::RESP_OKAY;
    end else if (ar_take) begin
      ar_ready_reg <= 1'b0;
      r_valid_reg <= 1'b1;
      r_data_reg <= read_word(S_AXI_ARADDR[11:2], latch_reg, FAULT_LIVE, release_delay_reg,
                              phase_offset_reg, irq_status_reg, irq_mask_reg);
      r_resp_reg <= is_mapped(S_AXI_ARADDR[11:2]) ? fap_pkg::RESP_OKAY : fap_pkg::RESP_SLVERR;
    end else if (r_valid_reg && S_AXI_RREADY) begin
      ar_ready_reg <= 1'b1;
      r_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      release_prev_reg <= 1'b0;
      irq_status_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      release_prev_reg <= release_reg;
      // an event in the read cycle survives the clear-on-read
      irq_status_reg <= (rd_status ? '0 : irq_status_reg) | irq_event;
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign S_AXI_AWREADY = aw_ready_reg;
  assign S_AXI_WREADY = w_ready_reg;
  assign S_AXI_BVALID = b_valid_reg;
  assign S_AXI_BRESP = b_resp_reg;
  assign S_AXI_ARREADY = ar_ready_reg;
  assign S_AXI_RVALID = r_valid_reg;
  assign S_AXI_RDATA = r_data_reg;
  assign S_AXI_RRESP = r_resp_reg;
  assign AUDIO_RELEASE = release_reg;
  assign PWM_FRAME_START = frame_start_reg;
  assign IRQ = irq_reg;

endmodule // fap_regs

// file: fap_regs_sva.sv
// checker for fap_regs: bus handshakes, reserved read bits, release and frame timing
// assumes it is bound to fap_regs and sees only that module's ports
`timescale 1ns/10ps
module fap_regs_sva #(
  parameter int RELEASE_SHORT_CYCLES = fap_pkg::RELEASE_SHORT_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic SILENCE_PIN_N,
  input wire logic AUDIO_RELEASE,
  input wire logic PWM_FRAME_START
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  a_write_answer: assert property ((S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY) |-> ##2 S_AXI_BVALID)
    else $error("write response not on time");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read response not on time");
  a_read_single: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read response repeated");
  a_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address taken during response");
  a_w_blocked: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken during response");
  a_chan_reserved: assert property ((S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[11:3] == 9'h08E) |=>
    (S_AXI_RDATA & 32'hFFFFFFF2) == 32'h0) else $error("channel latch reserved bits set");
  a_dev_reserved: assert property ((S_AXI_ARVALID && S_AXI_ARREADY &&
    (S_AXI_ARADDR[11:2] == 10'h11E || S_AXI_ARADDR[11:2] == 10'h11A)) |=> (S_AXI_RDATA & 32'hFFFFFF08) == 32'h0)
    else $error("device vector reserved bits set");
  a_release_drop: assert property ($fell(SILENCE_PIN_N) |-> ##[1:4] !AUDIO_RELEASE)
    else $error("audio not stopped after pin low");
  a_release_wait: assert property ($rose(AUDIO_RELEASE) |-> $past(SILENCE_PIN_N, RELEASE_SHORT_CYCLES))
    else $error("audio released too early");
  a_frame_pulse: assert property (PWM_FRAME_START |=> !PWM_FRAME_START)
    else $error("frame start longer than one cycle");
  c_write: cover property (S_AXI_BVALID);
  c_release: cover property ($rose(AUDIO_RELEASE));
  c_frame: cover property (PWM_FRAME_START);
endmodule // fap_regs_sva

bind fap_regs fap_regs_sva #(.RELEASE_SHORT_CYCLES(RELEASE_SHORT_CYCLES)) u_sva (
  .REF_CLK(REF_CLK), .SRST(SRST), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .SILENCE_PIN_N(SILENCE_PIN_N), .AUDIO_RELEASE(AUDIO_RELEASE), .PWM_FRAME_START(PWM_FRAME_START));

// file: tb.sv
// testbench for fap_regs: axi4-lite master tasks, random faults, release and phase timing
// assumes fap_pkg, fap_regs and fap_regs_sva are compiled first
`timescale 1ns/10ps
module tb;
  // ****
  // signals
  // ****
  localparam int LONG_C = 300;
  localparam int SHORT_C = 30;
  logic clk = 1'h0, srst = 1'h1, awv = 1'h0, wv = 1'h0, arv = 1'h0, pin_n = 1'h0, sync = 1'h0;
  logic brdy = 1'h1, rrdy = 1'h1;
  logic [3:0] strb = 4'hF;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0, rd_q, r;
  logic [17:0] acc = 18'h0;
  logic [1:0] rr, br;
  logic [6:0] ph [4] = '{7'h00, 7'h01, 7'h10, 7'h0F};
  fap_pkg::fap_fault_type live = '0;
  wire logic awr, wrdy, bv, arr, rv, rel, fs, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int failures = 0, tests_run = 0, seed = 32'hb240, n, base, tgt;
  fap_regs #(.RELEASE_LONG_CYCLES(LONG_C), .RELEASE_SHORT_CYCLES(SHORT_C), .PWM_PERIOD_CYCLES(64)) u_dut (
    .REF_CLK(clk), .SRST(srst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(strb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy), .FAULT_LIVE(live),
    .SILENCE_PIN_N(pin_n), .PWM_SYNC_IN(sync), .AUDIO_RELEASE(rel), .PWM_FRAME_START(fs), .IRQ(irq));
  initial begin
    forever #2 clk = ~clk;
  end
  // ****
  // tasks
  // ****
  task automatic results();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, seen, exp);
    end
  endtask
  // expected read words: only the defined fault bits may read back set
  function automatic logic [31:0] ch_exp(input logic [4:0] v);
    return {27'h0000000, v & fap_pkg::CH_FAULT_VALID};
  endfunction
  function automatic logic [31:0] dev_exp(input logic [7:0] v);
    return {24'h000000, v & fap_pkg::DEV_FAULT_VALID};
  endfunction
  // a 64-cycle period gives four cycles a step; a full turn of sixteen steps wraps to zero
  function automatic int frame_lag(input logic [6:0] p);
    return 4 * int'(p[3:0]);
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      failures++;
      results();
    end
  endtask
  // ready lines stay high, so each response is taken at the edge it is first seen
  task automatic axw(input logic [9:0] idx, input logic [31:0] d);
    int k = 0;
    awa <= {idx, 2'h0};
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    do begin
      @(posedge clk);
      if (awr === 1'h1) awv <= 1'h0;
      if (wrdy === 1'h1) wv <= 1'h0;
      k++;
    end while (bv !== 1'h1 && k < 60);
    br = bresp;
    tmo(k, 60);
  endtask
  task automatic axr(input logic [9:0] idx);
    int k = 0;
    ara <= {idx, 2'h0};
    arv <= 1'h1;
    do begin
      @(posedge clk);
      if (arr === 1'h1) arv <= 1'h0;
      k++;
    end while (rv !== 1'h1 && k < 60);
    rd_q = rdata;
    rr = rresp;
    tmo(k, 60);
  endtask
  // ****
  // sequence
  // ****
  initial begin
    cyc(20);
    srst <= 1'h0;
    cyc(1);
    for (int i = 0; i < 6; i++) begin
      axr(10'h11C + 10'(i > 2 ? i + 35 : i));
      chk(rd_q, (i == 3) ? 32'h3 : 32'h0);
    end
    axr(10'h15F);
    chk(rd_q, 32'h0);
    chk(32'(rr), 32'h0);
    axr(10'h3FF);
    chk({rd_q[29:0], rr}, 32'h2);
    axw(10'h3FF, 32'h1);
    chk(32'(br), 32'h2);
    axw(10'h171, 32'h7);
    for (int i = 0; i < 6; i++) begin
      r = (i == 0) ? 32'h3FFFF : $random(seed);
      live <= fap_pkg::fap_fault_type'(r[17:0]);
      acc = acc | r[17:0];
      axr(10'h11A);
      chk(rd_q, dev_exp(r[7:0]));
      live <= '0;
      cyc(1);
    end
    cyc(2);
    chk(32'(irq), 32'h1);
    axr(10'h11C);
    chk(rd_q, ch_exp(acc[17:13]));
    axr(10'h11D);
    chk(rd_q, ch_exp(acc[12:8]));
    axr(10'h11E);
    chk(rd_q, dev_exp(acc[7:0]));
    axr(10'h170);
    chk(rd_q, 32'h7);
    axr(10'h170);
    chk(rd_q, 32'h0);
    cyc(2);
    chk(32'(irq), 32'h0);
    axw(10'h109, 32'h0);
    axr(10'h11E);
    chk(rd_q, 32'h000000F7);
    axw(10'h109, 32'h1);
    for (int i = 0; i < 3; i++) begin
      axr(10'h11C + 10'(i));
      chk(rd_q, 32'h0);
    end
    // a masked event must still be recorded in status
    axw(10'h171, 32'h0);
    live <= fap_pkg::fap_fault_type'(18'h02000);
    cyc(1);
    live <= '0;
    cyc(3);
    chk(32'(irq), 32'h0);
    axr(10'h170);
    chk(rd_q, 32'h1);
    axr(10'h11C);
    chk(rd_q, 32'h1);
    for (int i = 0; i < 4; i++) begin
      axw(10'h15F, 32'(ph[i]));
      axr(10'h15F);
      chk(rd_q, 32'(ph[i]));
      n = 0;
      while (fs !== 1'h1 && n < 200) begin
        cyc(1);
        n++;
      end
      tmo(n, 200);
      sync <= 1'h1;
      n = 0;
      do begin
        cyc(1);
        n++;
      end while (fs !== 1'h1 && n < 200);
      tmo(n, 200);
      sync <= 1'h0;
      if (i == 0) base = n;
      chk(32'(n - base), 32'(frame_lag(ph[i])));
    end
    // a write without byte lane 0 must leave the phase field alone
    strb <= 4'hE;
    axw(10'h15F, 32'h5);
    strb <= 4'hF;
    chk(32'(br), 32'h0);
    axr(10'h15F);
    chk(rd_q, 32'h0000000F);
    for (int i = 0; i < 2; i++) begin
      tgt = i ? SHORT_C : LONG_C;
      axw(10'h142, i ? 32'hD : 32'h3);
      chk(32'(rel), 32'h0);
      pin_n <= 1'h1;
      n = 0;
      do begin
        cyc(1);
        n++;
      end while (rel !== 1'h1 && n < 400);
      tmo(n, 400);
      chk(32'(n >= tgt && n <= tgt + 6), 32'h1);
      pin_n <= 1'h0;
      cyc(6);
      chk(32'(rel), 32'h0);
    end
    axr(10'h170);
    chk(rd_q, 32'h8);
    results();
  end
endmodule // tb
